// ---- src/qub_pkg.sv ----
// Package of constants shared by the quad UART host bus block
package qub_pkg;
    // ********************************************************
    // Widths and counts
    // ********************************************************
    localparam int          QUB_CHANNELS   = 4;
    localparam int          QUB_REG_ADDR_W = 3;
    localparam int          QUB_DATA_W     = 8;
    localparam int          QUB_REGS       = 8;
    localparam int          QUB_CHSEL_W    = 2;
    // Register index of the interrupt enable register inside each channel
    localparam logic [2:0]  QUB_IER_IDX    = 3'h1;
    // Register index of the interrupt status register inside each channel
    localparam logic [2:0]  QUB_ISR_IDX    = 3'h2;
    // Reset value of every storage register
    localparam logic [7:0]  QUB_REG_RST    = 8'h00;
    // Interrupt status read when a channel has nothing pending
    localparam logic [7:0]  QUB_ISR_IDLE   = 8'h01;
    // Bus style select values
    localparam logic        QUB_MODE_PROC  = 1'b0;
    localparam logic        QUB_MODE_STRB  = 1'b1;
    // Transmit line idle level
    localparam logic        QUB_TX_IDLE    = 1'b1;
    // Bus access kinds
    typedef enum logic [1:0] {QUB_ACC_NONE, QUB_ACC_READ, QUB_ACC_WRITE} qub_acc_t;
endpackage : qub_pkg

// ---- src/qub_edge_detect.sv ----
// Falling edge detector for a host strobe sampled on the system clock
`timescale 1ns/1ns
module qub_edge_detect (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_level,
    output logic      o_fall
);
    logic level_r;

    // Strobes idle high, so reset the history high to avoid a false edge
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_r <= 1'b1;
        end else begin
            level_r <= i_level;
        end
    end

    assign o_fall = level_r & ~i_level;
endmodule : qub_edge_detect

// ---- src/qub_host_port.sv ----
// Host bus port of the quad UART: strobes, reset polarity and shared interrupt
// Operation
// - In processor mode all four channel interrupts merge onto one request.
// - Request goes low when any channel has an enabled source pending.
// - In strobe mode the shared pin becomes the channel A interrupt.
// - In strobe mode a high reset input clears all registers and outputs.
// - During reset transmit outputs stay idle and receive inputs are ignored.
// - In processor mode the reset input is active low, same effect.
// - Strobe mode read falling edge drives selected register onto data bus.
// - Strobe mode write falling edge stores data bus into selected register.
// - In processor mode the write strobe acts as read/write direction.
`timescale 1ns/1ns
module qub_host_port (
    input  wire logic                               i_clock,
    input  wire logic                               i_rst_n,
    input  wire logic                               i_bus_style,
    input  wire logic                               i_ext_reset,
    input  wire logic                               i_chip_sel_n,
    input  wire logic [qub_pkg::QUB_CHSEL_W-1:0]    i_chan_sel,
    input  wire logic [qub_pkg::QUB_REG_ADDR_W-1:0] i_reg_addr,
    input  wire logic [qub_pkg::QUB_DATA_W-1:0]     i_data,
    input  wire logic                               i_io_read_strobe_n,
    input  wire logic                               i_io_write_strobe_n,
    input  wire logic [qub_pkg::QUB_CHANNELS-1:0]   i_chan_event,
    input  wire logic [qub_pkg::QUB_CHANNELS-1:0]   i_serial_rx,
    output logic [qub_pkg::QUB_DATA_W-1:0]          o_data,
    output logic                                    o_data_oe,
    output logic                                    o_irq_n_out,
    output logic                                    o_irq_n_oe,
    output logic                                    o_channel_a_interrupt,
    output logic [qub_pkg::QUB_CHANNELS-1:0]        o_serial_tx,
    output logic [qub_pkg::QUB_CHANNELS-1:0]        o_rx_sampled,
    output logic                                    o_in_reset
);
    import qub_pkg::*;

    // ********************************************************
    // Reset qualification
    // ********************************************************
    logic dev_reset;
    logic strobe_mode;
    logic read_fall;
    logic write_fall;
    logic ds_fall;
    logic [QUB_DATA_W-1:0] regs_r [QUB_CHANNELS][QUB_REGS];
    logic [QUB_CHANNELS-1:0] pend_r;
    logic [QUB_CHANNELS-1:0] chan_req;
    logic sel_ok;
    qub_acc_t acc;

    assign strobe_mode = (i_bus_style == QUB_MODE_STRB);
    assign dev_reset = strobe_mode ? i_ext_reset : ~i_ext_reset;
    assign sel_ok = ~i_chip_sel_n;

    // ********************************************************
    // Strobe decoding
    // ********************************************************
    qub_edge_detect u_rd_edge (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_level (i_io_read_strobe_n),
        .o_fall  (read_fall)
    );
    qub_edge_detect u_wr_edge (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_level (i_io_write_strobe_n),
        .o_fall  (write_fall)
    );
    // Processor mode uses the read strobe pin as its data strobe; chip select low
    qub_edge_detect u_ds_edge (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_level (i_io_read_strobe_n | i_chip_sel_n),
        .o_fall  (ds_fall)
    );

    // Access kind per bus style; refused in reset or when deselected
    // Strobes are sampled, so each low phase must span at least one clock
    always_comb begin
        acc = QUB_ACC_NONE;
        if (dev_reset) begin
            acc = QUB_ACC_NONE;
        end else if (strobe_mode) begin
            if (read_fall && sel_ok) begin
                acc = QUB_ACC_READ;
            end else if (write_fall && sel_ok) begin
                acc = QUB_ACC_WRITE;
            end
        end else if (ds_fall) begin
            acc = i_io_write_strobe_n ? QUB_ACC_READ : QUB_ACC_WRITE;
        end
    end

    // ********************************************************
    // Channel register storage
    // ********************************************************
    genvar gc;
    genvar gr;
    generate
        for (gc = 0; gc < QUB_CHANNELS; gc++) begin : g_chan
            for (gr = 0; gr < QUB_REGS; gr++) begin : g_reg
                always_ff @(posedge i_clock or negedge i_rst_n) begin
                    if (!i_rst_n) begin
                        regs_r[gc][gr] <= QUB_REG_RST;
                    end else if (dev_reset) begin
                        regs_r[gc][gr] <= QUB_REG_RST;
                    end else if (acc == QUB_ACC_WRITE
                                 && i_chan_sel == QUB_CHSEL_W'(gc)
                                 && i_reg_addr == QUB_REG_ADDR_W'(gr)) begin
                        regs_r[gc][gr] <= i_data;
                    end
                end
            end
            // Pending events stick until the host reads that channel's status,
            // so a polling host sees each event once if that channel's enable bit is set
            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pend_r[gc] <= 1'b0;
                end else if (dev_reset) begin
                    pend_r[gc] <= 1'b0;
                end else if (i_chan_event[gc]) begin
                    // Set wins over a simultaneous status read
                    pend_r[gc] <= 1'b1;
                end else if (acc == QUB_ACC_READ && i_chan_sel == QUB_CHSEL_W'(gc)
                             && i_reg_addr == QUB_ISR_IDX) begin
                    pend_r[gc] <= 1'b0;
                end
            end
            assign chan_req[gc] = pend_r[gc] & regs_r[gc][QUB_IER_IDX][0];
        end
    endgenerate

    // ********************************************************
    // Read data path
    // ********************************************************
    // Data is captured at the fall so it stays steady while the host samples
    // drive selected register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= QUB_REG_RST;
        end else if (dev_reset) begin
            o_data <= QUB_REG_RST;
        end else if (acc == QUB_ACC_READ) begin
            if (i_reg_addr == QUB_ISR_IDX) begin
                o_data <= chan_req[i_chan_sel] ? QUB_REG_RST : QUB_ISR_IDLE;
            end else begin
                o_data <= regs_r[i_chan_sel][i_reg_addr];
            end
        end
    end

    // Data bus driven only while a read strobe is held low
    // Release lags the strobe by a clock, which is why strobes need a gap
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data_oe <= 1'b0;
        end else if (dev_reset) begin
            o_data_oe <= 1'b0;
        end else if (acc == QUB_ACC_READ) begin
            o_data_oe <= 1'b1;
        end else if (i_io_read_strobe_n || i_chip_sel_n) begin
            o_data_oe <= 1'b0;
        end
    end

    // ********************************************************
    // Interrupt outputs
    // ********************************************************
    // Pin only ever pulls low; the board pull-up supplies the idle high
    // merge channels in processor mode
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_n_out <= 1'b0;
            o_irq_n_oe  <= 1'b0;
        end else begin
            o_irq_n_out <= 1'b0;
            o_irq_n_oe  <= !dev_reset && !strobe_mode && (|chan_req);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_channel_a_interrupt <= 1'b0;
        end else begin
            o_channel_a_interrupt <= !dev_reset && strobe_mode && chan_req[0];
        end
    end

    // ********************************************************
    // Serial line gating during reset
    // ********************************************************
    // idle transmit, ignore receive
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_tx  <= {QUB_CHANNELS{QUB_TX_IDLE}};
            o_rx_sampled <= {QUB_CHANNELS{QUB_TX_IDLE}};
            o_in_reset   <= 1'b1;
        end else if (dev_reset) begin
            o_serial_tx  <= {QUB_CHANNELS{QUB_TX_IDLE}};
            o_rx_sampled <= {QUB_CHANNELS{QUB_TX_IDLE}};
            o_in_reset   <= 1'b1;
        end else begin
            o_serial_tx  <= {QUB_CHANNELS{QUB_TX_IDLE}};
            o_rx_sampled <= i_serial_rx;
            o_in_reset   <= 1'b0;
        end
    end
endmodule : qub_host_port

// ---- dv/qub_host_port_monitor.sv ----
// Assertion checker for the quad UART host bus port
`timescale 1ns/1ns
module qub_host_port_monitor (
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_bus_style,
    input wire logic       i_ext_reset,
    input wire logic       i_chip_sel_n,
    input wire logic       i_io_read_strobe_n,
    input wire logic       i_io_write_strobe_n,
    input wire logic       o_data_oe,
    input wire logic       o_irq_n_out,
    input wire logic       o_irq_n_oe,
    input wire logic       o_channel_a_interrupt,
    input wire logic [3:0] o_serial_tx,
    input wire logic [3:0] o_rx_sampled,
    input wire logic       o_in_reset
);
    logic dev_rst;
    // Reset pin polarity follows the bus style
    assign dev_rst = i_bus_style ? i_ext_reset : !i_ext_reset;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_rd_fall;
        i_bus_style && !i_chip_sel_n && !dev_rst && !o_in_reset && $fell(i_io_read_strobe_n);
    endsequence
    sequence s_rst_seen;
        o_in_reset && !o_data_oe && !o_irq_n_oe;
    endsequence
    AST_READ_DRIVE: assert property (s_rd_fall |-> ##[1:2] o_data_oe)
        else $error("read fall did not drive the data bus");
    AST_OE_RELEASE: assert property (
        (i_io_read_strobe_n || i_chip_sel_n) |=> !o_data_oe)
        else $error("data bus driven after strobe release");
    AST_RESET_STRB: assert property (i_bus_style && i_ext_reset |=> s_rst_seen)
        else $error("high reset pin ignored in strobe style");
    AST_RESET_PROC: assert property (!i_bus_style && !i_ext_reset |=> s_rst_seen)
        else $error("low reset pin ignored in processor style");
    AST_RESET_LINES: assert property (
        o_in_reset |-> o_serial_tx == 4'hf && o_rx_sampled == 4'hf)
        else $error("serial lines active during reset");
    AST_IRQ_LOW: assert property (
        o_irq_n_oe |-> !o_irq_n_out && !o_in_reset && !o_channel_a_interrupt)
        else $error("shared request not driven low");
    AST_IRQ_PROC_ONLY: assert property (i_bus_style [*2] |-> !o_irq_n_oe)
        else $error("shared request driven in strobe style");
    AST_CHANNEL_A_INTERRUPT_STRB_ONLY: assert property (!i_bus_style [*2] |-> !o_channel_a_interrupt)
        else $error("channel A output active in processor style");
    AST_DIR_WRITE: assert property (
        !i_bus_style && !i_io_write_strobe_n |=> !o_data_oe)
        else $error("data bus driven during a write direction");
endmodule : qub_host_port_monitor

bind qub_host_port qub_host_port_monitor i_mon (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_bus_style(i_bus_style), .i_ext_reset(i_ext_reset), .i_chip_sel_n(i_chip_sel_n),
    .i_io_read_strobe_n(i_io_read_strobe_n), .i_io_write_strobe_n(i_io_write_strobe_n),
    .o_data_oe(o_data_oe), .o_irq_n_out(o_irq_n_out), .o_irq_n_oe(o_irq_n_oe),
    .o_channel_a_interrupt(o_channel_a_interrupt), .o_serial_tx(o_serial_tx),
    .o_rx_sampled(o_rx_sampled), .o_in_reset(o_in_reset));

// ---- dv/qub_host_model.sv ----
// Behavioural host CPU driving the eight-bit parallel bus
`timescale 1ns/1ns
module qub_host_model (
    input  wire logic       i_clock,
    input  wire logic       i_bus_style,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_data_oe,
    output logic            o_chip_sel_n = 1'b1,
    output logic [1:0]      o_chan_sel = 2'h0,
    output logic [2:0]      o_reg_addr = 3'h0,
    output logic [7:0]      o_data = 8'h00,
    output logic            o_rd_n = 1'b1,
    output logic            o_wr_n = 1'b1
);
    // One access addresses a channel by select lines
    task automatic access(input logic wr, input logic [1:0] ch, input logic [2:0] idx,
                          inout logic [7:0] d);
        @(posedge i_clock);
        o_chip_sel_n <= 1'b0;
        o_chan_sel <= ch;
        o_reg_addr <= idx;
        o_data <= d;
        o_rd_n <= wr & i_bus_style;
        o_wr_n <= !wr;
        repeat (2) @(posedge i_clock);
        // Read data is taken at the edge the device answers
        for (int n = 0; n < 6 && !wr && i_rd_data_oe !== 1'b1; n++) @(posedge i_clock);
        if (!wr) d = (i_rd_data_oe === 1'b1) ? i_rd_data : 8'hxx;
        o_chip_sel_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        // Released bus shows the inverse, never a stale match
        o_data <= ~d;
        @(posedge i_clock);
    endtask : access
endmodule : qub_host_model

// ---- dv/qub_host_port_bench.sv ----
// Self-checking bench for the quad UART host bus port
`timescale 1ns/1ns
module qub_host_port_bench;
    import qub_pkg::*;
    logic i_clock = 1'b0, i_rst_n = 1'b0, style = 1'b1, ext_rst = 1'b0;
    logic [3:0] ev = 4'h0, rx = 4'hf, tx, rx_s;
    logic cs_n, rd_n, wr_n, oe, irq_out, irq_oe, int_a, in_rst;
    logic [1:0] ch;
    logic [2:0] adr;
    logic [7:0] wd, rdat;
    int miscompares = 0;
    int n_checks = 0;
    always #5 i_clock = ~i_clock;
    qub_host_port i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus_style(style),
        .i_ext_reset(ext_rst), .i_chip_sel_n(cs_n), .i_chan_sel(ch), .i_reg_addr(adr),
        .i_data(wd), .i_io_read_strobe_n(rd_n), .i_io_write_strobe_n(wr_n), .i_chan_event(ev),
        .i_serial_rx(rx), .o_data(rdat), .o_data_oe(oe), .o_irq_n_out(irq_out),
        .o_irq_n_oe(irq_oe), .o_channel_a_interrupt(int_a), .o_serial_tx(tx),
        .o_rx_sampled(rx_s), .o_in_reset(in_rst));
    qub_host_model i_host (.i_clock(i_clock), .i_bus_style(style), .i_rd_data(rdat),
        .i_rd_data_oe(oe), .o_chip_sel_n(cs_n), .o_chan_sel(ch), .o_reg_addr(adr),
        .o_data(wd), .o_rd_n(rd_n), .o_wr_n(wr_n));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Switch style with the reset pin at its idle level
    task automatic set_mode(input logic m);
        @(posedge i_clock);
        style <= m;
        ext_rst <= ~m;
        repeat (2) @(posedge i_clock);
    endtask : set_mode
    task automatic wr(input logic [1:0] c, input logic [2:0] i, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        i_host.access(1'b1, c, i, v);
    endtask : wr
    task automatic rd(input string nm, input logic [1:0] c, input logic [2:0] i,
                      input logic [7:0] e);
        logic [7:0] v;
        v = 8'h00;
        i_host.access(1'b0, c, i, v);
        chk(nm, e, v);
    endtask : rd
    task automatic pulse(input logic [3:0] p);
        @(posedge i_clock);
        ev <= p;
        @(posedge i_clock);
        ev <= 4'h0;
        repeat (3) @(posedge i_clock);
    endtask : pulse
    task automatic t_rw;
        logic [7:0] pat;
        for (int m = 1; m >= 0; m--) begin
            set_mode(m[0]);
            for (int c = 0; c < 4; c++) begin
                pat = 8'h5a ^ c[7:0] ^ {m[3:0], 4'h0};
                wr(c[1:0], 3'h7, pat);
            end
            for (int c = 0; c < 4; c++) begin
                pat = 8'h5a ^ c[7:0] ^ {m[3:0], 4'h0};
                rd("reg", c[1:0], 3'h7, pat);
            end
        end
        $display("test rw done");
    endtask : t_rw
    task automatic t_irq;
        set_mode(QUB_MODE_PROC);
        wr(2'h2, QUB_IER_IDX, 8'h01);
        pulse(4'h2);
        chk("irq_off", 8'h00, {7'h0, irq_oe});
        pulse(4'h4);
        // Pin pulled low: enable high, driven value low
        chk("irq_on", 8'h02, {6'h0, irq_oe, irq_out});
        // Channel 1 is pending but not enabled, so it reads as idle
        for (int c = 0; c < 4; c++) begin
            rd("isr", c[1:0], QUB_ISR_IDX, (c == 2) ? 8'h00 : QUB_ISR_IDLE);
        end
        repeat (2) @(posedge i_clock);
        chk("irq_free", 8'h00, {7'h0, irq_oe});
        $display("test irq done");
    endtask : t_irq
    task automatic t_channel_a_interrupt;
        set_mode(QUB_MODE_STRB);
        wr(2'h0, QUB_IER_IDX, 8'h01);
        pulse(4'h1);
        chk("int_a", 8'h01, {6'h0, irq_oe, int_a});
        rd("isr_a", 2'h0, QUB_ISR_IDX, 8'h00);
        chk("int_a_free", 8'h00, {7'h0, int_a});
        $display("test channel_a_interrupt done");
    endtask : t_channel_a_interrupt
    task automatic t_reset;
        for (int m = 1; m >= 0; m--) begin
            set_mode(m[0]);
            wr(2'h0, 3'h7, 8'hc3);
            wr(2'h0, QUB_IER_IDX, 8'h01);
            pulse(4'h1);
            rx <= 4'h0;
            ext_rst <= m[0];
            repeat (2) @(posedge i_clock);
            chk("rst", 8'h01, {6'h0, irq_oe | int_a, in_rst});
            chk("lines", 8'hff, {tx, rx_s});
            ext_rst <= ~m[0];
            repeat (2) @(posedge i_clock);
            // Receive input is followed again once reset is gone
            chk("rx_live", 8'hf0, {tx, rx_s});
            rx <= 4'hf;
            rd("cleared", 2'h0, 3'h7, QUB_REG_RST);
        end
        $display("test reset done");
    endtask : t_reset
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        t_rw();
        t_irq();
        t_channel_a_interrupt();
        t_reset();
        end_of_test();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
endmodule : qub_host_port_bench
